// *** src/refclk_pkg.sv ***
// Package: register map, field layout, reset values and timing for the reference clock startup block
package refclk_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_SOURCE_CFG  = 8'h00;
  localparam logic [7:0] REG_DIV_INT     = 8'h04;
  localparam logic [7:0] REG_DIV_FRAC_LO = 8'h08;
  localparam logic [7:0] REG_DIV_FRAC_HI = 8'h0c;
  localparam logic [7:0] REG_DIV_SEC     = 8'h10;
  localparam logic [7:0] REG_FREQ_TRIM   = 8'h14;
  localparam logic [7:0] REG_SETUP_DONE  = 8'h18;
  localparam logic [7:0] REG_CLK_STATUS  = 8'h1c;
  localparam logic [7:0] REG_INFO        = 8'h20;
  localparam logic [7:0] REG_OUT_ENABLE  = 8'h24;
  localparam logic [7:0] REG_MAILBOX     = 8'h28;
  localparam logic [7:0] REG_IRQ_STATUS  = 8'h2c;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h30;
  localparam logic [7:0] REG_STRAPS      = 8'h34;

  // Field positions
  localparam int XTAL_EN_BIT     = 0;
  localparam int DOUBLER_EN_BIT  = 1;
  localparam int LOCK_N_BIT      = 3;
  localparam int READY_BIT       = 7;
  localparam int IRQ_LOCK_BIT    = 0;
  localparam int IRQ_READY_BIT   = 1;
  localparam int IRQ_DROP_BIT    = 2;
  localparam int IRQ_MBX_REJ_BIT = 3;

  // Reset values and the ready status code
  localparam logic [1:0]  SOURCE_CFG_RST = 2'h0;
  localparam logic [31:0] DIV_INT_RST    = 32'h0000_0000;
  localparam logic [31:0] DIV_FRAC_RST   = 32'h0000_0000;
  localparam logic [31:0] DIV_SEC_RST    = 32'h0000_0001;
  localparam logic [31:0] TRIM_RST       = 32'h0000_0000;
  localparam logic [9:0]  OUT_EN_RST     = 10'h000;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
  localparam logic [1:0]  STATE_READY    = 2'h3;

  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int STRAP_HOLD_MS    = 550;
  localparam int STRAP_HOLD_CYC   = STRAP_HOLD_MS * CLK_MHZ * 1000;
  localparam int LOCK_WAIT_US     = 100;
  localparam int LOCK_WAIT_CYC    = LOCK_WAIT_US * CLK_MHZ;

  typedef enum logic [1:0] {ST_IDLE, ST_LOCKING, ST_READY} pll_state_t;
endpackage

// *** src/pin_sync.sv ***
// Three-stage pin synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule

// *** src/refclk_pll_startup_control.sv ***
// Reference clock source, doubler, PLL setup registers and startup sequencing
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module refclk_pll_startup_control #(
  parameter int STRAP_HOLD_CYC = refclk_pkg::STRAP_HOLD_CYC,
  parameter int LOCK_WAIT_CYC  = refclk_pkg::LOCK_WAIT_CYC,
  parameter int OUT_COUNT      = 10
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic [31:0]          WB_ADR_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  input  wire logic                 WB_WE_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_CYC_I,
  output logic                      WB_ACK_O,
  output logic                      WB_ERR_O,
  input  wire logic                 PLL_LOCK,
  input  wire logic                 HOST_SELECT_STRAP,
  input  wire logic                 SERIAL_OUT_STRAP,
  output logic                      XTAL_DRIVER_EN,
  output logic                      SINGLE_ENDED_REF_SEL,
  output logic                      REF_DOUBLER_EN,
  output logic [31:0]               PLL_DIV_INT,
  output logic [35:0]               PLL_DIV_FRAC,
  output logic [31:0]               PLL_DIV_SEC,
  output logic [31:0]               FREQ_TRIM,
  output logic [OUT_COUNT-1:0]      OUT_ENABLE,
  output logic                      HOST_IF_SPI,
  output logic                      STRAPS_VALID,
  output logic [31:0]               MAILBOX_DATA,
  output logic                      MAILBOX_WRITE,
  output logic                      IRQ
);
  logic [1:0]           refclk_source_config;
  logic [31:0]          div_int;
  logic [35:0]          div_frac;
  logic [31:0]          div_sec;
  logic [31:0]          trim;
  logic                 setup_done;
  logic [OUT_COUNT-1:0] out_en;
  logic [31:0]          mailbox;
  logic [3:0]           irq_status;
  logic [3:0]           irq_mask;
  logic                 lock_sync;
  logic                 host_sync;
  logic                 sout_sync;
  refclk_pkg::pll_state_t state;
  logic [31:0]          wait_cnt;
  logic [31:0]          strap_cnt;
  logic                 strap_done;
  logic                 host_spi;
  logic                 sout_level;
  logic                 lock_seen;

  logic [1:0]           next_refclk_source_config;
  logic [31:0]          next_div_int;
  logic [35:0]          next_div_frac;
  logic [31:0]          next_div_sec;
  logic [31:0]          next_trim;
  logic                 next_setup_done;
  logic [OUT_COUNT-1:0] next_out_en;
  logic [31:0]          next_mailbox;
  logic                 next_mailbox_write;
  logic [3:0]           next_irq_status;
  logic [3:0]           next_irq_mask;
  logic [31:0]          next_dat_o;
  logic                 next_ack;
  logic                 next_err;
  refclk_pkg::pll_state_t next_state;
  logic [31:0]          next_wait_cnt;
  logic [31:0]          next_strap_cnt;
  logic                 next_strap_done;
  logic                 next_host_spi;
  logic                 next_sout_level;
  logic                 next_lock_seen;

  logic                 req;
  logic                 wr;
  logic                 rd;
  logic                 locked;
  logic                 ready;
  logic [3:0]           events;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lock is asynchronous to the bus clock
  pin_sync #(.WIDTH(3)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .pin   ({PLL_LOCK, HOST_SELECT_STRAP, SERIAL_OUT_STRAP}),
    .level ({lock_sync, host_sync, sout_sync})
  );

  assign req    = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign wr     = req && WB_WE_I;
  assign rd     = req && !WB_WE_I;
  assign locked = lock_sync && (state != refclk_pkg::ST_IDLE);
  assign ready  = (state == refclk_pkg::ST_READY);

  // Startup sequence and strap capture
  always_comb begin
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_strap_cnt  = strap_cnt;
    next_strap_done = strap_done;
    next_host_spi   = host_spi;
    next_sout_level = sout_level;
    next_lock_seen  = lock_sync;
    if (!strap_done) begin
      next_host_spi   = host_sync;
      next_sout_level = sout_sync;
      if (strap_cnt >= 32'(STRAP_HOLD_CYC - 1)) begin
        next_strap_done = 1'b1;
      end else begin
        next_strap_cnt = strap_cnt + 32'h1;
      end
    end
    unique case (state)
      refclk_pkg::ST_IDLE: begin
        next_wait_cnt = '0;
        if (setup_done) begin
          next_state = refclk_pkg::ST_LOCKING;
        end
      end
      refclk_pkg::ST_LOCKING: begin
        // Lock must stay up for the whole wait before ready is declared
        if (!lock_sync) begin
          next_wait_cnt = '0;
        end else if (wait_cnt >= 32'(LOCK_WAIT_CYC - 1)) begin
          next_state = refclk_pkg::ST_READY;
        end else begin
          next_wait_cnt = wait_cnt + 32'h1;
        end
      end
      refclk_pkg::ST_READY: begin
        if (!lock_sync) begin
          next_state    = refclk_pkg::ST_LOCKING;
          next_wait_cnt = '0;
        end
      end
    endcase
    if (!setup_done) begin
      next_state = refclk_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= refclk_pkg::ST_IDLE;
      wait_cnt   <= '0;
      strap_cnt  <= '0;
      strap_done <= 1'b0;
      host_spi   <= 1'b0;
      sout_level <= 1'b0;
      lock_seen  <= 1'b0;
    end else begin
      state      <= next_state;
      wait_cnt   <= next_wait_cnt;
      strap_cnt  <= next_strap_cnt;
      strap_done <= next_strap_done;
      host_spi   <= next_host_spi;
      sout_level <= next_sout_level;
      lock_seen  <= next_lock_seen;
    end
  end

  assign events[refclk_pkg::IRQ_LOCK_BIT]    = lock_sync && !lock_seen;
  assign events[refclk_pkg::IRQ_READY_BIT]   = (next_state == refclk_pkg::ST_READY) && !ready;
  assign events[refclk_pkg::IRQ_DROP_BIT]    = !lock_sync && lock_seen;
  assign events[refclk_pkg::IRQ_MBX_REJ_BIT] = wr && (WB_ADR_I[7:0] == refclk_pkg::REG_MAILBOX) && !(ready && locked);

  // Register file and Wishbone slave
  always_comb begin
    next_refclk_source_config = refclk_source_config;
    next_div_int       = div_int;
    next_div_frac      = div_frac;
    next_div_sec       = div_sec;
    next_trim          = trim;
    next_setup_done    = setup_done;
    next_out_en        = out_en;
    next_mailbox       = mailbox;
    next_mailbox_write = 1'b0;
    next_irq_mask      = irq_mask;
    next_irq_status    = irq_status;
    next_dat_o         = '0;
    next_ack           = 1'b0;
    next_err           = 1'b0;
    if (req) begin
      next_ack = 1'b1;
      unique case (WB_ADR_I[7:0])
        refclk_pkg::REG_SOURCE_CFG: begin
          next_dat_o = {30'h0, refclk_source_config};
          if (wr && WB_SEL_I[0]) begin
            next_refclk_source_config = WB_DAT_I[1:0];
          end
        end
        refclk_pkg::REG_DIV_INT: begin
          next_dat_o = div_int;
          if (wr) next_div_int = merge(div_int, WB_DAT_I, WB_SEL_I);
        end
        refclk_pkg::REG_DIV_FRAC_LO: begin
          next_dat_o = div_frac[31:0];
          if (wr) next_div_frac[31:0] = merge(div_frac[31:0], WB_DAT_I, WB_SEL_I);
        end
        refclk_pkg::REG_DIV_FRAC_HI: begin
          next_dat_o = {28'h0, div_frac[35:32]};
          if (wr && WB_SEL_I[0]) next_div_frac[35:32] = WB_DAT_I[3:0];
        end
        refclk_pkg::REG_DIV_SEC: begin
          next_dat_o = div_sec;
          if (wr) next_div_sec = merge(div_sec, WB_DAT_I, WB_SEL_I);
        end
        refclk_pkg::REG_FREQ_TRIM: begin
          next_dat_o = trim;
          if (wr) next_trim = merge(trim, WB_DAT_I, WB_SEL_I);
        end
        refclk_pkg::REG_SETUP_DONE: begin
          next_dat_o = {31'h0, setup_done};
          if (wr && WB_SEL_I[0]) next_setup_done = WB_DAT_I[0];
        end
        refclk_pkg::REG_CLK_STATUS: begin
          next_dat_o = {28'h0, !locked, 1'b0, ready ? refclk_pkg::STATE_READY : 2'h0};
        end
        refclk_pkg::REG_INFO: begin
          next_dat_o = 32'(ready) << refclk_pkg::READY_BIT;
        end
        refclk_pkg::REG_OUT_ENABLE: begin
          next_dat_o = 32'(out_en);
          if (wr) next_out_en = OUT_COUNT'(merge(32'(out_en), WB_DAT_I, WB_SEL_I));
        end
        refclk_pkg::REG_MAILBOX: begin
          next_dat_o = mailbox;
          // Ready lags a lock loss by a cycle, so gate on both
          if (wr && ready && locked) begin
            next_mailbox       = merge(mailbox, WB_DAT_I, WB_SEL_I);
            next_mailbox_write = 1'b1;
          end
        end
        refclk_pkg::REG_IRQ_STATUS: begin
          next_dat_o = {28'h0, irq_status};
          if (rd) next_irq_status = '0;
        end
        refclk_pkg::REG_IRQ_MASK: begin
          next_dat_o = {28'h0, irq_mask};
          if (wr && WB_SEL_I[0]) next_irq_mask = WB_DAT_I[3:0];
        end
        refclk_pkg::REG_STRAPS: begin
          next_dat_o = {29'h0, strap_done, sout_level, host_spi};
        end
        default: begin
          next_ack = 1'b0;
          next_err = 1'b1;
        end
      endcase
    end
    // Set wins over read-clear
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      refclk_source_config <= refclk_pkg::SOURCE_CFG_RST;
      div_int       <= refclk_pkg::DIV_INT_RST;
      div_frac      <= 36'(refclk_pkg::DIV_FRAC_RST);
      div_sec       <= refclk_pkg::DIV_SEC_RST;
      trim          <= refclk_pkg::TRIM_RST;
      setup_done    <= 1'b0;
      out_en        <= OUT_COUNT'(refclk_pkg::OUT_EN_RST);
      mailbox       <= '0;
      MAILBOX_WRITE <= 1'b0;
      irq_status    <= '0;
      irq_mask      <= refclk_pkg::IRQ_MASK_RST;
      WB_DAT_O      <= '0;
      WB_ACK_O      <= 1'b0;
      WB_ERR_O      <= 1'b0;
    end else begin
      refclk_source_config <= next_refclk_source_config;
      div_int       <= next_div_int;
      div_frac      <= next_div_frac;
      div_sec       <= next_div_sec;
      trim          <= next_trim;
      setup_done    <= next_setup_done;
      out_en        <= next_out_en;
      mailbox       <= next_mailbox;
      MAILBOX_WRITE <= next_mailbox_write;
      irq_status    <= next_irq_status;
      irq_mask      <= next_irq_mask;
      WB_DAT_O      <= next_dat_o;
      WB_ACK_O      <= next_ack;
      WB_ERR_O      <= next_err;
    end
  end

  // Registered pin outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      XTAL_DRIVER_EN       <= 1'b0;
      SINGLE_ENDED_REF_SEL <= 1'b1;
      REF_DOUBLER_EN       <= 1'b0;
      PLL_DIV_INT          <= '0;
      PLL_DIV_FRAC         <= '0;
      PLL_DIV_SEC          <= '0;
      FREQ_TRIM            <= '0;
      OUT_ENABLE           <= '0;
      HOST_IF_SPI          <= 1'b0;
      STRAPS_VALID         <= 1'b0;
      MAILBOX_DATA         <= '0;
      IRQ                  <= 1'b0;
    end else begin
      XTAL_DRIVER_EN       <= next_refclk_source_config[refclk_pkg::XTAL_EN_BIT];
      SINGLE_ENDED_REF_SEL <= !next_refclk_source_config[refclk_pkg::XTAL_EN_BIT];
      REF_DOUBLER_EN       <= next_refclk_source_config[refclk_pkg::DOUBLER_EN_BIT];
      PLL_DIV_INT          <= next_div_int;
      PLL_DIV_FRAC         <= next_div_frac;
      PLL_DIV_SEC          <= next_div_sec;
      FREQ_TRIM            <= next_trim;
      OUT_ENABLE           <= next_out_en;
      HOST_IF_SPI          <= next_host_spi;
      STRAPS_VALID         <= next_strap_done;
      MAILBOX_DATA         <= next_mailbox;
      IRQ                  <= |(next_irq_status & irq_mask);
    end
  end
endmodule

// *** tb/refclk_startup_props.sv ***
// Checker: concurrent properties on the startup control block's ports
`timescale 1ns/1ps
module refclk_startup_props #(
  parameter int STRAP_HOLD_CYC = 20,
  parameter int OUT_COUNT      = 10
) (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic [31:0]          WB_ADR_I,
  input wire logic [31:0]          WB_DAT_O,
  input wire logic                 WB_WE_I,
  input wire logic                 WB_STB_I,
  input wire logic                 WB_CYC_I,
  input wire logic                 WB_ACK_O,
  input wire logic                 WB_ERR_O,
  input wire logic                 PLL_LOCK,
  input wire logic                 XTAL_DRIVER_EN,
  input wire logic                 SINGLE_ENDED_REF_SEL,
  input wire logic                 REF_DOUBLER_EN,
  input wire logic [OUT_COUNT-1:0] OUT_ENABLE,
  input wire logic                 HOST_IF_SPI,
  input wire logic                 STRAPS_VALID,
  input wire logic                 MAILBOX_WRITE
);
  int unsigned since_rst;
  int unsigned next_since_rst;
  logic        req;
  logic [7:0]  adr;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign adr = WB_ADR_I[7:0];
  // Saturates so the window checks stay cheap on long runs
  always_comb begin
    next_since_rst = (since_rst < STRAP_HOLD_CYC + 16) ? since_rst + 1 : since_rst;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      since_rst <= 0;
    end else begin
      since_rst <= next_since_rst;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_answer;
    ##1 (WB_ACK_O ^ WB_ERR_O) ##1 (!WB_ACK_O && !WB_ERR_O);
  endsequence
  sequence s_frozen;
    ##1 STRAPS_VALID && $stable(HOST_IF_SPI);
  endsequence
  a_wb_answer_once: assert property (req |-> s_answer) else $error("bus answer missing or too long");
  a_wb_err_unmapped: assert property (req && adr > 8'h34 |=> WB_ERR_O) else $error("unmapped access not refused");
  a_wb_ack_mapped: assert property (req && adr <= 8'h34 && adr[1:0] == 2'h0 |=> WB_ACK_O) else $error("mapped access not acked");
  a_rd_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
  a_src_exclusive: assert property (XTAL_DRIVER_EN != SINGLE_ENDED_REF_SEL) else $error("reference select clash");
  a_src_by_write: assert property ($changed({XTAL_DRIVER_EN, REF_DOUBLER_EN}) |->
    $past(req && WB_WE_I && adr == refclk_pkg::REG_SOURCE_CFG)) else $error("source changed without write");
  a_out_by_write: assert property ($changed(OUT_ENABLE) |->
    $past(req && WB_WE_I && adr == refclk_pkg::REG_OUT_ENABLE)) else $error("outputs changed without write");
  a_mbx_locked: assert property (MAILBOX_WRITE |-> $past(PLL_LOCK, 8) && !$past(MAILBOX_WRITE))
    else $error("mailbox accepted while unlocked");
  a_strap_early: assert property (since_rst + 1 < STRAP_HOLD_CYC |-> !STRAPS_VALID)
    else $error("strap window closed early");
  a_strap_late: assert property (since_rst == STRAP_HOLD_CYC + 8 |-> STRAPS_VALID)
    else $error("strap window never closed");
  a_strap_frozen: assert property (STRAPS_VALID |-> s_frozen) else $error("host select moved after window");
  c_mbx_taken: cover property (MAILBOX_WRITE);
endmodule
bind refclk_pll_startup_control refclk_startup_props #(.STRAP_HOLD_CYC(STRAP_HOLD_CYC), .OUT_COUNT(OUT_COUNT))
  i_refclk_startup_props (.CLK(CLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
  .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PLL_LOCK(PLL_LOCK),
  .XTAL_DRIVER_EN(XTAL_DRIVER_EN), .SINGLE_ENDED_REF_SEL(SINGLE_ENDED_REF_SEL), .REF_DOUBLER_EN(REF_DOUBLER_EN),
  .OUT_ENABLE(OUT_ENABLE), .HOST_IF_SPI(HOST_IF_SPI), .STRAPS_VALID(STRAPS_VALID), .MAILBOX_WRITE(MAILBOX_WRITE));

// *** tb/pll_ref_model.sv ***
// Behavioural PLL and reference: locks once one source and nonzero dividers are set
`timescale 1ns/1ps
module pll_ref_model #(
  parameter int LOCK_DELAY = 12
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        xtal_en,
  input  wire logic        se_sel,
  input  wire logic [31:0] div_int,
  input  wire logic [31:0] div_sec,
  input  wire logic        drop,
  output logic             lock
);
  int   cnt;
  logic ok;
  // Exactly one reference and a usable multiplier
  assign ok = (xtal_en ^ se_sel) && div_int != 32'h0 && div_sec != 32'h0 && !drop;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || !ok) begin
      cnt <= 0;
      lock <= 1'b0;
    end else if (cnt == LOCK_DELAY) begin
      lock <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** tb/refclk_pll_startup_control_bench.sv ***
// Testbench: register-level bring-up, refusal and reset scenarios
`timescale 1ns/1ps
module refclk_pll_startup_control_bench;
  logic CLK = 1'b0, RST_N = 1'b0, WB_WE_I = 1'b0, WB_STB_I = 1'b0, WB_CYC_I = 1'b0, drop = 1'b0;
  logic HOST_SELECT_STRAP = 1'b1, SERIAL_OUT_STRAP = 1'b0, PLL_LOCK, WB_ACK_O, WB_ERR_O, IRQ, er;
  logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, WB_DAT_O, PLL_DIV_INT, PLL_DIV_SEC, FREQ_TRIM, MAILBOX_DATA, rd;
  logic [3:0] WB_SEL_I = 4'hf;
  logic XTAL_DRIVER_EN, SINGLE_ENDED_REF_SEL, REF_DOUBLER_EN, HOST_IF_SPI, STRAPS_VALID, MAILBOX_WRITE;
  logic [35:0] PLL_DIV_FRAC;
  logic [9:0] OUT_ENABLE;
  int fails = 0, checks = 0, mbx_n = 0;
  always #2 CLK = ~CLK;
  refclk_pll_startup_control #(.STRAP_HOLD_CYC(20), .LOCK_WAIT_CYC(8), .OUT_COUNT(10)) i_refclk_pll_startup_control (
    .CLK(CLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
    .WB_SEL_I(WB_SEL_I), .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
    .PLL_LOCK(PLL_LOCK), .HOST_SELECT_STRAP(HOST_SELECT_STRAP), .SERIAL_OUT_STRAP(SERIAL_OUT_STRAP),
    .XTAL_DRIVER_EN(XTAL_DRIVER_EN), .SINGLE_ENDED_REF_SEL(SINGLE_ENDED_REF_SEL), .REF_DOUBLER_EN(REF_DOUBLER_EN),
    .PLL_DIV_INT(PLL_DIV_INT), .PLL_DIV_FRAC(PLL_DIV_FRAC), .PLL_DIV_SEC(PLL_DIV_SEC), .FREQ_TRIM(FREQ_TRIM),
    .OUT_ENABLE(OUT_ENABLE), .HOST_IF_SPI(HOST_IF_SPI), .STRAPS_VALID(STRAPS_VALID), .MAILBOX_DATA(MAILBOX_DATA),
    .MAILBOX_WRITE(MAILBOX_WRITE), .IRQ(IRQ));
  pll_ref_model i_pll_ref_model (.clk(CLK), .rst_n(RST_N), .xtal_en(XTAL_DRIVER_EN), .se_sel(SINGLE_ENDED_REF_SEL),
    .div_int(PLL_DIV_INT), .div_sec(PLL_DIV_SEC), .drop(drop), .lock(PLL_LOCK));
  // Counted mid-cycle so the count never races the edge that raises it
  always @(negedge CLK) begin
    if (MAILBOX_WRITE === 1'b1) mbx_n++;
  end
  task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= {24'h0, a};
    WB_DAT_I <= d;
    @(posedge CLK);
    while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1) begin
      if (n == 20) begin
        fails++;
        print_verdict();
      end
      n++;
      @(posedge CLK);
    end
    rd = WB_DAT_O;
    er = WB_ERR_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
    @(posedge CLK);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    wb(1'b0, a, 32'h0);
    while ((rd & m) !== v) begin
      if (n == 100) begin
        fails++;
        print_verdict();
      end
      n++;
      wb(1'b0, a, 32'h0);
    end
    check(rd & m, v);
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (IRQ !== 1'b1) begin
      if (n == 50) begin
        fails++;
        print_verdict();
      end
      n++;
      @(posedge CLK);
    end
  endtask
  task do_reset;
    RST_N <= 1'b0;
    // Reset held low, scaled to 8 cycles
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
  endtask
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  initial begin
    do_reset();
    rdchk(refclk_pkg::REG_SOURCE_CFG, 32'h0);
    rdchk(refclk_pkg::REG_DIV_SEC, 32'h1);
    rdchk(refclk_pkg::REG_OUT_ENABLE, 32'h0);
    check(OUT_ENABLE, 10'h000);
    check({XTAL_DRIVER_EN, SINGLE_ENDED_REF_SEL, PLL_DIV_SEC}, {2'b01, 32'h1});
    wb(1'b0, refclk_pkg::REG_CLK_STATUS, 32'h0);
    check(rd[3], 1'b1);
    // Straps held through the window, then moved
    poll(refclk_pkg::REG_STRAPS, 32'h4, 32'h4);
    HOST_SELECT_STRAP <= 1'b0;
    SERIAL_OUT_STRAP <= 1'b1;
    repeat (6) @(posedge CLK);
    rdchk(refclk_pkg::REG_STRAPS, 32'h5);
    check(HOST_IF_SPI, 1'b1);
    for (int v = 0; v < 4; v++) begin
      wb(1'b1, refclk_pkg::REG_SOURCE_CFG, v);
      check({XTAL_DRIVER_EN, SINGLE_ENDED_REF_SEL, REF_DOUBLER_EN}, {v[0], ~v[0], v[1]});
      rdchk(refclk_pkg::REG_SOURCE_CFG, v);
    end
    wb(1'b1, 8'h38, 32'hffff_ffff);
    check(er, 1'b1);
    wb(1'b1, refclk_pkg::REG_CLK_STATUS, 32'h0);
    wb(1'b0, refclk_pkg::REG_CLK_STATUS, 32'h0);
    check(rd[3], 1'b1);
    // Mailbox write before ready must be refused and flagged
    wb(1'b1, refclk_pkg::REG_IRQ_MASK, 32'hf);
    wb(1'b1, refclk_pkg::REG_MAILBOX, 32'hdead_beef);
    wait_irq();
    rdchk(refclk_pkg::REG_IRQ_STATUS, 32'h8);
    check(mbx_n, 0);
    repeat (2) @(posedge CLK);
    check(IRQ, 1'b0);
    // Crystal with doubler, dividers, trim, then setup done
    wb(1'b1, refclk_pkg::REG_SOURCE_CFG, 32'h3);
    wb(1'b1, refclk_pkg::REG_DIV_INT, 32'd62);
    wb(1'b1, refclk_pkg::REG_DIV_FRAC_LO, 32'h0000_1234);
    wb(1'b1, refclk_pkg::REG_DIV_FRAC_HI, 32'h8);
    wb(1'b1, refclk_pkg::REG_DIV_SEC, 32'h2);
    wb(1'b1, refclk_pkg::REG_FREQ_TRIM, 32'h21);
    check(PLL_DIV_FRAC, 36'h8_0000_1234);
    check({PLL_DIV_INT, PLL_DIV_SEC[3:0]}, {32'd62, 4'h2});
    check(FREQ_TRIM, 32'h21);
    wb(1'b1, refclk_pkg::REG_SETUP_DONE, 32'h1);
    poll(refclk_pkg::REG_CLK_STATUS, 32'hb, 32'h3);
    poll(refclk_pkg::REG_INFO, 32'h80, 32'h80);
    rdchk(refclk_pkg::REG_IRQ_STATUS, 32'h3);
    wb(1'b1, refclk_pkg::REG_MAILBOX, 32'h1357_9bdf);
    check(mbx_n, 1);
    check(MAILBOX_DATA, 32'h1357_9bdf);
    wb(1'b1, refclk_pkg::REG_OUT_ENABLE, 32'h3ff);
    check(OUT_ENABLE, 10'h3ff);
    drop <= 1'b1;
    wait_irq();
    rdchk(refclk_pkg::REG_IRQ_STATUS, 32'h4);
    wb(1'b0, refclk_pkg::REG_CLK_STATUS, 32'h0);
    check({rd[3], rd[1:0] == 2'h3}, 2'b10);
    // Second reset in mid-run, straps now pick the two-wire host
    drop <= 1'b0;
    wb(1'b1, refclk_pkg::REG_SETUP_DONE, 32'h0);
    repeat (20) @(posedge CLK);
    rdchk(refclk_pkg::REG_CLK_STATUS, 32'h8);
    HOST_SELECT_STRAP <= 1'b0;
    do_reset();
    check(OUT_ENABLE, 10'h000);
    rdchk(refclk_pkg::REG_SOURCE_CFG, 32'h0);
    rdchk(refclk_pkg::REG_IRQ_MASK, 32'h0);
    poll(refclk_pkg::REG_STRAPS, 32'h4, 32'h4);
    rdchk(refclk_pkg::REG_STRAPS, 32'h6);
    check(HOST_IF_SPI, 1'b0);
    print_verdict();
  end
endmodule
